// [rtl/ugt_gap_timer.sv]
// ugt_gap_timer: one inter-packet gap timer
// assumes: start and abort come from logic on the same clock
`timescale 1ns/1ps
module ugt_gap_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [ugt_pkg::TO_W-1:0] step,
  input wire logic [ugt_pkg::TO_W-1:0] limit,
  // result
  output logic expired
);
  import ugt_pkg::*;

  logic armed_q;
  logic expired_q;
  logic [TO_W-1:0] accum_q;
  logic [TO_W:0] accumNext;
  wire reached;

  // -------------------------------------------------------------
  // elapsed time, one phy clock worth of step per cycle
  // -------------------------------------------------------------
  assign accumNext = {1'b0, accum_q} + {1'b0, step};
  assign reached = accumNext >= {1'b0, limit};

  // arm on start, disarm on activity or expiry
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
      accum_q <= '0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= armed_q && !abort && !start && reached;
      if (start) begin
        armed_q <= 1'b1;
        accum_q <= '0;
      end else if (abort || (armed_q && reached)) begin
        armed_q <= 1'b0;
      end else if (armed_q) begin
        accum_q <= accumNext[TO_W-1:0];
      end
    end
  end

  assign expired = expired_q;

endmodule

// [rtl/ugt_gap_trim_cfg.sv]
// ugt_gap_trim_cfg: gap timeout trim register and the two gap timers
// assumes: register port, image and line-state inputs share sys_clk
//
// Summary of operation
// [RULE1] hs trim clocks scaled, added to hs timeout
// [RULE2] hs base timeout within 736..816 bit times
// [RULE3] hs adds 8 bits/clock at 60, 16 at 30
// [RULE4] fs trim clocks scaled, added to fs timeout
// [RULE5] fs base timeout within 16..18 bit times
// [RULE6] fs adds 0.2 at 60, 0.4/0.25 otherwise
// [RULE7] always use the 60 MHz factors
// [RULE8] scale selector: off, general, suspend, both
// [RULE9] scale selector resets to 00, real timing
// [RULE10] software keeps scale at 00 normally
// [RULE11] hs trim default eeprom/otp/zero, restored on resets
// [RULE12] fs trim default eeprom/otp/zero, restored on resets
// [RULE13] reserved bits read zero, writes ignored
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module ugt_gap_trim_cfg (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire ugt_pkg::ugt_bus_req_type busReq,
  output logic [31:0] readData,
  // configuration image and reset sources
  input wire ugt_pkg::ugt_cfg_image_type cfgImage,
  input wire logic usbBusReset,
  input wire logic lightSoftReset,
  // line-state side
  input wire logic hsGapStart,
  input wire logic fsGapStart,
  input wire logic lineActive,
  // timing results
  output logic [ugt_pkg::TO_W-1:0] hsGapTimeout,
  output logic [ugt_pkg::TO_W-1:0] fsGapTimeout,
  output logic hsGapExpired,
  output logic fsGapExpired,
  output logic scaleGeneral,
  output logic scaleSuspend
);
  import ugt_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0] hsGapTrimClocks_q;
  logic [2:0] fsGapTrimClocks_q;
  logic [1:0] scaleMode_q;
  logic bootLoad_q;
  logic [31:0] readData_q;
  logic [TO_W-1:0] hsGapTimeout_q;
  logic [TO_W-1:0] fsGapTimeout_q;
  logic scaleGeneral_q;
  logic scaleSuspend_q;
  logic [31:0] regWord;
  ugt_scale_type scaleSel;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire regHit = busReq.addr == TRIM_REG_OFS;
  wire wrHit = busReq.wr && regHit;
  wire rdHit = busReq.rd && regHit;
  wire restoreNow = bootLoad_q || usbBusReset || lightSoftReset;
  wire [2:0] wrHsTrim = busReq.wdata[HS_TRIM_MSB:HS_TRIM_LSB];
  wire [2:0] wrFsTrim = busReq.wdata[FS_TRIM_MSB:FS_TRIM_LSB];
  wire [1:0] wrScale = busReq.wdata[SCALE_MSB:SCALE_LSB];

  // image value that a reset restores: eeprom, else otp, else zero
  wire [2:0] imgHsTrim = pickImage(cfgImage.eepromPresent, cfgImage.eepromHsTrim,
                                   cfgImage.otpProgrammed, cfgImage.otpHsTrim);
  wire [2:0] imgFsTrim = pickImage(cfgImage.eepromPresent, cfgImage.eepromFsTrim,
                                   cfgImage.otpProgrammed, cfgImage.otpFsTrim);

  // per-clock factors, fixed at the supported phy rate
  wire [TO_W-1:0] hsStep = hsBitsPerClk(PHY_CLK_MHZ); // [RULE3] [RULE7]
  wire [TO_W-1:0] fsStep = fsCbitsPerClk(PHY_CLK_MHZ); // [RULE6] [RULE7]

  // trimmed timeouts from the fixed standard bases
  wire [TO_W-1:0] hsTimeoutCalc =
    trimTimeout(HS_BASE_BITS, hsGapTrimClocks_q, hsStep); // [RULE1] [RULE2]
  wire [TO_W-1:0] fsTimeoutCalc =
    trimTimeout(FS_BASE_CBITS, fsGapTrimClocks_q, fsStep); // [RULE4] [RULE5]

  // scale selector decode
  assign scaleSel = ugt_scale_type'(scaleMode_q);

  // ---------------------------------------------------------------
  // register update
  // ---------------------------------------------------------------
  // image load one cycle after reset release
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bootLoad_q <= 1'b1;
    end else begin
      bootLoad_q <= 1'b0;
    end
  end

  // trims: image restore wins over a write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hsGapTrimClocks_q <= HS_TRIM_RST;
      fsGapTrimClocks_q <= FS_TRIM_RST;
    end else if (restoreNow) begin
      hsGapTrimClocks_q <= imgHsTrim; // [RULE11]
      fsGapTrimClocks_q <= imgFsTrim; // [RULE12]
    end else if (wrHit) begin
      hsGapTrimClocks_q <= wrHsTrim;
      fsGapTrimClocks_q <= wrFsTrim;
    end
  end

  // scale selector back to real timing on any reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst || restoreNow) begin
      scaleMode_q <= SCALE_RST; // [RULE9]
    end else if (wrHit) begin
      scaleMode_q <= wrScale;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // only defined fields are placed, everything else reads zero
  always_comb begin
    regWord = 32'h0; // [RULE13]
    regWord[HS_TRIM_MSB:HS_TRIM_LSB] = hsGapTrimClocks_q;
    regWord[FS_TRIM_MSB:FS_TRIM_LSB] = fsGapTrimClocks_q;
    regWord[SCALE_MSB:SCALE_LSB] = scaleMode_q;
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      readData_q <= 32'h0;
    end else if (rdHit) begin
      readData_q <= regWord;
    end else begin
      readData_q <= 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // timing outputs
  // ---------------------------------------------------------------
  // scale decode: bit 0 general timing, bit 1 suspend and resume
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scaleGeneral_q <= 1'b0;
      scaleSuspend_q <= 1'b0;
    end else begin
      case (scaleSel)
        SCALE_OFF: begin
          scaleGeneral_q <= 1'b0; // [RULE8]
          scaleSuspend_q <= 1'b0;
        end
        SCALE_GENERAL: begin
          scaleGeneral_q <= 1'b1;
          scaleSuspend_q <= 1'b0;
        end
        SCALE_SUSPEND: begin
          scaleGeneral_q <= 1'b0;
          scaleSuspend_q <= 1'b1;
        end
        default: begin
          scaleGeneral_q <= 1'b1;
          scaleSuspend_q <= 1'b1;
        end
      endcase
    end
  end

  // registered trimmed timeouts
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hsGapTimeout_q <= HS_BASE_BITS;
      fsGapTimeout_q <= FS_BASE_CBITS;
    end else begin
      hsGapTimeout_q <= hsTimeoutCalc;
      fsGapTimeout_q <= fsTimeoutCalc;
    end
  end

  // gap limits, shortened in the general and both scale-down modes
  wire [TO_W-1:0] hsLimit = scaleGeneral_q ? (hsGapTimeout_q >> SCALE_SHIFT) : hsGapTimeout_q;
  wire [TO_W-1:0] fsLimit = scaleGeneral_q ? (fsGapTimeout_q >> SCALE_SHIFT) : fsGapTimeout_q;

  // hs gap timer
  ugt_gap_timer hsTimer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(hsGapStart),
    .abort(lineActive),
    .step(hsStep),
    .limit(hsLimit),
    .expired(hsGapExpired)
  );

  // fs gap timer
  ugt_gap_timer fsTimer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(fsGapStart),
    .abort(lineActive),
    .step(fsStep),
    .limit(fsLimit),
    .expired(fsGapExpired)
  );

  // output drive
  assign readData = readData_q;
  assign hsGapTimeout = hsGapTimeout_q;
  assign fsGapTimeout = fsGapTimeout_q;
  assign scaleGeneral = scaleGeneral_q;
  assign scaleSuspend = scaleSuspend_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  logic pastValid_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pastValid_q <= 1'b0;
    end else begin
      pastValid_q <= 1'b1;
    end
  end

  chk_hs_trim_sum: assert property ( // [RULE1]
    pastValid_q |-> hsGapTimeout_q == 11'(800 + 8 * $past(hsGapTrimClocks_q)))
    else $error("hs timeout does not follow trim");

  chk_hs_base_window: assert property ( // [RULE2]
    pastValid_q |-> (11'(hsGapTimeout_q - 11'(8 * $past(hsGapTrimClocks_q))) >= HS_STD_MIN_BITS)
      && (11'(hsGapTimeout_q - 11'(8 * $past(hsGapTrimClocks_q))) <= HS_STD_MAX_BITS))
    else $error("hs base timeout outside window");

  chk_hs_step_size: assert property ( // [RULE3]
    pastValid_q && (hsGapTrimClocks_q == 3'h7) |=> hsGapTimeout == 11'h358)
    else $error("hs step per clock is not 8");

  chk_fs_trim_sum: assert property ( // [RULE4]
    pastValid_q |-> fsGapTimeout_q == 11'(1700 + 20 * $past(fsGapTrimClocks_q)))
    else $error("fs timeout does not follow trim");

  chk_fs_base_window: assert property ( // [RULE5]
    pastValid_q |-> (11'(fsGapTimeout_q - 11'(20 * $past(fsGapTrimClocks_q))) >= FS_STD_MIN_CBITS)
      && (11'(fsGapTimeout_q - 11'(20 * $past(fsGapTrimClocks_q))) <= FS_STD_MAX_CBITS))
    else $error("fs base timeout outside window");

  chk_phy_rate_fixed: assert property ( // [RULE6] [RULE7]
    (hsStep == 11'd8) && (fsStep == 11'd20))
    else $error("per-clock factor not the 60 MHz one");

  chk_scale_decode: assert property ( // [RULE8]
    pastValid_q |-> (scaleGeneral_q == $past(scaleMode_q[0]))
      && (scaleSuspend_q == $past(scaleMode_q[1])))
    else $error("scale decode wrong");

  chk_scale_reset: assert property ( // [RULE9]
    $past(sys_rst) |-> (scaleMode_q == 2'h0) ##1 !scaleGeneral_q && !scaleSuspend_q)
    else $error("scale selector not cleared by reset");

  chk_reset_restore: assert property ( // [RULE11] [RULE12]
    (usbBusReset || lightSoftReset) |=> (hsGapTrimClocks_q == $past(imgHsTrim))
      && (fsGapTrimClocks_q == $past(imgFsTrim)) && (scaleMode_q == 2'h0))
    else $error("trim not restored from image");

  chk_reserved_zero: assert property ( // [RULE13]
    busReq.rd |=> (readData[31:16] == 16'h0) && (readData[12:7] == 6'h0)
      && (readData[3:2] == 2'h0))
    else $error("reserved bits read nonzero");

  chk_unmapped_zero: assert property (
    busReq.rd && !regHit |=> readData == 32'h0)
    else $error("unmapped read not zero");

  chk_write_lands: assert property ( // [RULE13]
    wrHit && !restoreNow |=> (hsGapTrimClocks_q == $past(wrHsTrim))
      && (fsGapTrimClocks_q == $past(wrFsTrim)) && (scaleMode_q == $past(wrScale)))
    else $error("register write did not land in its fields");

  chk_boot_load: assert property ( // [RULE11] [RULE12]
    $past(sys_rst) |=> (hsGapTrimClocks_q == $past(imgHsTrim))
      && (fsGapTrimClocks_q == $past(imgFsTrim)))
    else $error("trim not loaded from image after reset");

  chk_hs_pulse_once: assert property (
    hsGapExpired |=> !hsGapExpired)
    else $error("hs gap expiry longer than one cycle");

  chk_fs_pulse_once: assert property (
    fsGapExpired |=> !fsGapExpired)
    else $error("fs gap expiry longer than one cycle");

  cov_trim_write: cover property (wrHit && (wrHsTrim != 3'h0) ##1 (hsGapTrimClocks_q != 3'h0));
  cov_restore: cover property (lightSoftReset && (hsGapTrimClocks_q != imgHsTrim));
  cov_hs_expire: cover property (hsGapStart ##[1:200] hsGapExpired);
  cov_scale_both: cover property (scaleGeneral_q && scaleSuspend_q);

endmodule

// [rtl/ugt_pkg.sv]
// ugt_pkg: constants, types and helpers of the inter-packet gap trim block
// assumes: one 40 MHz system clock, timeouts modelled at a 60 MHz PHY rate
package ugt_pkg;

  // ---------------------------------------------------------------
  // register map and field layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] TRIM_REG_OFS = 12'h084;
  localparam int HS_TRIM_LSB = 13;
  localparam int HS_TRIM_MSB = 15;
  localparam int FS_TRIM_LSB = 4;
  localparam int FS_TRIM_MSB = 6;
  localparam int SCALE_LSB = 0;
  localparam int SCALE_MSB = 1;
  localparam logic [2:0] HS_TRIM_RST = 3'h0;
  localparam logic [2:0] FS_TRIM_RST = 3'h0;
  localparam logic [1:0] SCALE_RST = 2'h0;

  // ---------------------------------------------------------------
  // timing: hs in bit times, fs in hundredths of a bit time
  // ---------------------------------------------------------------
  localparam int TO_W = 11;
  localparam logic [10:0] HS_STD_MIN_BITS = 11'h2e0;  // 736
  localparam logic [10:0] HS_STD_MAX_BITS = 11'h330;  // 816
  localparam logic [10:0] HS_BASE_BITS = 11'h320;     // 800
  localparam logic [10:0] FS_STD_MIN_CBITS = 11'h640; // 16.00
  localparam logic [10:0] FS_STD_MAX_CBITS = 11'h708; // 18.00
  localparam logic [10:0] FS_BASE_CBITS = 11'h6a4;    // 17.00
  localparam int PHY_CLK_MHZ = 60;
  localparam int SCALE_SHIFT = 2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCALE_OFF, SCALE_GENERAL, SCALE_SUSPEND, SCALE_BOTH
  } ugt_scale_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ugt_bus_req_type;

  typedef struct packed {
    logic eepromPresent;
    logic otpProgrammed;
    logic [2:0] eepromHsTrim;
    logic [2:0] eepromFsTrim;
    logic [2:0] otpHsTrim;
    logic [2:0] otpFsTrim;
  } ugt_cfg_image_type;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // hs bit times per phy clock
  function automatic logic [10:0] hsBitsPerClk(input int mhz);
    if (mhz == 30) begin
      return 11'h010;
    end else begin
      return 11'h008;
    end
  endfunction

  // fs hundredths of a bit time per phy clock
  function automatic logic [10:0] fsCbitsPerClk(input int mhz);
    if (mhz == 30) begin
      return 11'h028;
    end else if (mhz == 48) begin
      return 11'h019;
    end else begin
      return 11'h014;
    end
  endfunction

  // base timeout plus trim clocks times the per-clock factor
  function automatic logic [10:0] trimTimeout(input logic [10:0] base,
                                              input logic [2:0] trim,
                                              input logic [10:0] factor);
    logic [21:0] prod;
    prod = {19'h0, trim} * {11'h0, factor};
    return 11'(base + prod[10:0]);
  endfunction

  // image source priority: eeprom, then otp, then zero
  function automatic logic [2:0] pickImage(input logic eePresent,
                                           input logic [2:0] eeVal,
                                           input logic otpProg,
                                           input logic [2:0] otpVal);
    if (eePresent) begin
      return eeVal;
    end else if (otpProg) begin
      return otpVal;
    end else begin
      return 3'h0;
    end
  endfunction

endpackage

// [tb/ugt_gap_trim_cfg_tb.sv]
// ugt_gap_trim_cfg_tb: self-checking bench of the gap timeout trim block
// assumes: ugt_pkg, the design and ugt_line_model are compiled before it
`timescale 1ns/1ps
module ugt_gap_trim_cfg_tb;
  import ugt_pkg::*;
  // ---------------------------------------------------------------
  // signals and table
  // ---------------------------------------------------------------
  typedef struct {
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [10:0] hsTo;
    logic [10:0] fsTo;
    logic [1:0] scale;
  } ugt_row_type;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  ugt_bus_req_type busReq = '0;
  logic [31:0] readData;
  ugt_cfg_image_type cfgImage;
  logic usbBusReset = 1'b0;
  logic lightSoftReset = 1'b0;
  logic [1:0] imgSel = 2'h0;
  logic [1:0] gapReq = 2'h0;
  logic lineReq = 1'b0;
  logic hsGapStart;
  logic fsGapStart;
  logic lineActive;
  logic [10:0] hsGapTimeout;
  logic [10:0] fsGapTimeout;
  logic hsGapExpired;
  logic fsGapExpired;
  logic scaleGeneral;
  logic scaleSuspend;
  int errTotal = 0;
  int cmpCount = 0;
  // write word, readback, hs and fs timeouts, scale outputs
  ugt_row_type rows [5] = '{
    '{32'hffffffff, 32'h0000e073, 11'h358, 11'h730, 2'h3},
    '{32'h00002010, 32'h00002010, 11'h328, 11'h6b8, 2'h0},
    '{32'h0000a052, 32'h0000a052, 11'h348, 11'h708, 2'h2},
    '{32'hffff1f8d, 32'h00000001, 11'h320, 11'h6a4, 2'h1},
    '{32'h00000000, 32'h00000000, 11'h320, 11'h6a4, 2'h0}};

  // ---------------------------------------------------------------
  // clock, design and far side
  // ---------------------------------------------------------------
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  ugt_gap_trim_cfg dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq),
    .readData(readData), .cfgImage(cfgImage), .usbBusReset(usbBusReset),
    .lightSoftReset(lightSoftReset), .hsGapStart(hsGapStart), .fsGapStart(fsGapStart),
    .lineActive(lineActive), .hsGapTimeout(hsGapTimeout), .fsGapTimeout(fsGapTimeout),
    .hsGapExpired(hsGapExpired), .fsGapExpired(fsGapExpired),
    .scaleGeneral(scaleGeneral), .scaleSuspend(scaleSuspend));
  ugt_line_model line_u (.sys_clk(sys_clk), .imgSel(imgSel), .gapReq(gapReq),
    .lineReq(lineReq), .cfgImage(cfgImage), .hsGapStart(hsGapStart),
    .fsGapStart(fsGapStart), .lineActive(lineActive));

  // ---------------------------------------------------------------
  // tasks: all but check and conclude entered and left right after a rising edge
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic busWrite(input logic [11:0] addr, input logic [31:0] data);
    busReq.addr <= addr;
    busReq.wdata <= data;
    busReq.wr <= 1'b1;
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic busRead(input logic [11:0] addr, input logic [31:0] exp);
    busReq.addr <= addr;
    busReq.rd <= 1'b1;
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1;
    check(readData, exp, "read data");
    @(posedge sys_clk);
  endtask
  // read data must be gone again, outputs must follow the fields
  task automatic afterRead(input logic [10:0] hs, input logic [10:0] fs, input logic [1:0] sc);
    #1;
    check(readData, 32'h0, "read data after its cycle");
    check({21'h0, hsGapTimeout}, {21'h0, hs}, "hs timeout");
    check({21'h0, fsGapTimeout}, {21'h0, fs}, "fs timeout");
    check({30'h0, scaleSuspend, scaleGeneral}, {30'h0, sc}, "scale outputs");
    @(posedge sys_clk);
  endtask
  // start a gap timer, count cycles to its pulse, optional line break
  task automatic gapTime(input logic [1:0] kind, input int expN, input int brkAt);
    int n;
    gapReq <= kind;
    @(posedge sys_clk);
    gapReq <= 2'h0;
    for (n = 1; n < 400; n++) begin
      #1;
      if (kind[0] ? hsGapExpired === 1'b1 : fsGapExpired === 1'b1) break;
      @(posedge sys_clk);
      lineReq <= (n == brkAt);
    end
    if (n < 400) @(posedge sys_clk);
    check(32'(n % 400), 32'(expN), "gap length");
    if (n == 400 && expN != 0) conclude();
  endtask
  // restore from image while software writes in the same cycle
  task automatic restore(input logic [1:0] sel, input logic viaUsb);
    imgSel <= sel;
    @(posedge sys_clk);
    usbBusReset <= viaUsb;
    lightSoftReset <= !viaUsb;
    busWrite(TRIM_REG_OFS, 32'h0000ffff);
    usbBusReset <= 1'b0;
    lightSoftReset <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    busRead(TRIM_REG_OFS, 32'h0);
    afterRead(11'h320, 11'h6a4, 2'h0);
    foreach (rows[i]) begin
      busWrite(TRIM_REG_OFS, rows[i].wdata);
      busRead(TRIM_REG_OFS, rows[i].rdata);
      afterRead(rows[i].hsTo, rows[i].fsTo, rows[i].scale);
    end
    gapTime(2'h1, 101, 0);
    gapTime(2'h2, 86, 0);
    gapTime(2'h1, 0, 10);
    busWrite(TRIM_REG_OFS, 32'h0000e070);
    @(posedge sys_clk);
    gapTime(2'h1, 108, 0);
    gapTime(2'h2, 93, 0);
    busWrite(TRIM_REG_OFS, 32'h00000001);
    @(posedge sys_clk);
    gapTime(2'h1, 26, 0);
    gapTime(2'h2, 23, 0);
    busWrite(TRIM_REG_OFS, 32'h00000002);
    @(posedge sys_clk);
    gapTime(2'h1, 101, 0);
    // unmapped place, then reserved bits stay clear
    busWrite(12'h088, 32'hffffffff);
    busRead(12'h088, 32'h0);
    busRead(TRIM_REG_OFS, 32'h00000002);
    busWrite(TRIM_REG_OFS, 32'h00000003);
    restore(2'h2, 1'b0);
    busRead(TRIM_REG_OFS, 32'h0000a020);
    afterRead(11'h348, 11'h6cc, 2'h0);
    restore(2'h1, 1'b1);
    busRead(TRIM_REG_OFS, 32'h00006060);
    afterRead(11'h338, 11'h71c, 2'h0);
    // system reset in mid-run loads the image again
    busWrite(TRIM_REG_OFS, 32'h00000001);
    sys_rst <= 1'b1;
    imgSel <= 2'h2;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    busRead(TRIM_REG_OFS, 32'h0000a020);
    afterRead(11'h348, 11'h6cc, 2'h0);
    conclude();
  end
endmodule

// [tb/ugt_line_model.sv]
// ugt_line_model: far side of the trim block, image store and phy line state
// assumes: steered by the bench on sys_clk, no clock of its own
`timescale 1ns/1ps
module ugt_line_model (
  // clock
  input wire logic sys_clk,
  // bench controls
  input wire logic [1:0] imgSel,
  input wire logic [1:0] gapReq,
  input wire logic lineReq,
  // towards the block
  output ugt_pkg::ugt_cfg_image_type cfgImage,
  output logic hsGapStart,
  output logic fsGapStart,
  output logic lineActive
);
  import ugt_pkg::*;
  logic [1:0] busyCnt_q = 2'h0;
  // image: 2 eeprom and otp both present, 1 otp only, 0 blank
  assign cfgImage = '{eepromPresent: imgSel[1], otpProgrammed: |imgSel,
    eepromHsTrim: 3'h5, eepromFsTrim: 3'h2, otpHsTrim: 3'h3, otpFsTrim: 3'h6};
  // gap start pulses follow the bench request
  assign hsGapStart = gapReq[0];
  assign fsGapStart = gapReq[1];
  // line activity held for three cycles per request
  always_ff @(posedge sys_clk) begin
    busyCnt_q <= lineReq ? 2'h3 : ((busyCnt_q != 2'h0) ? busyCnt_q - 2'h1 : 2'h0);
  end
  assign lineActive = (busyCnt_q != 2'h0);
endmodule
